// ---- core/prs_pkg.sv ----
// Constants and types shared by the processor reset sequencer.
// Assumes a single 250 MHz core clock; all times are converted to cycles here.
package prs_pkg;

  localparam int unsigned PRS_CLK_PERIOD_NS = 4;

  // Time from both resets released to lock, PLL restarted
  localparam int unsigned PRS_COLD_SETTLE_NS = 2000;
  // Time from warm release to lock, PLL left running
  localparam int unsigned PRS_WARM_SETTLE_NS = 500;
  // Internal hold of the module reset for a watchdog reset
  localparam int unsigned PRS_SOFT_HOLD_NS   = 500;

  // Least times round up to whole cycles
  localparam int unsigned PRS_COLD_SETTLE_CYC =
    (PRS_COLD_SETTLE_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;
  localparam int unsigned PRS_WARM_SETTLE_CYC =
    (PRS_WARM_SETTLE_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;
  localparam int unsigned PRS_SOFT_HOLD_CYC   =
    (PRS_SOFT_HOLD_NS + PRS_CLK_PERIOD_NS - 1) / PRS_CLK_PERIOD_NS;

  localparam int unsigned PRS_CNT_W = 10;

  // Synchroniser reset value: inputs seen as asserted (low)
  localparam logic [1:0] PRS_SYNC_RST = 2'h0;

  // Bit of the timer status word that records a watchdog reset
  localparam int unsigned PRS_WARM_STATUS_BIT = 4;

  typedef enum logic [2:0]
  {
    PRS_S_COLD      = 3'b000,
    PRS_S_SETTLE    = 3'b001,
    PRS_S_RUN       = 3'b010,
    PRS_S_WARM_HOLD = 3'b011,
    PRS_S_SOFT_HOLD = 3'b100
  } prs_state_t;

  typedef enum logic [1:0]
  {
    PRS_M_COLD = 2'b00,
    PRS_M_WARM = 2'b01,
    PRS_M_SOFT = 2'b10
  } prs_mode_t;

  typedef struct packed
  {
    prs_state_t           state;
    logic [PRS_CNT_W-1:0] cnt;
    prs_mode_t            mode;
    logic                 cold_done;
    logic                 pll_reset;
    logic                 module_reset_n;
    logic                 lock;
    logic                 warm_status;
  } prs_regs_t;

  localparam prs_regs_t PRS_REGS_RST = '{
    state:          PRS_S_COLD,
    cnt:            10'h000,
    mode:           PRS_M_COLD,
    cold_done:      1'b0,
    pll_reset:      1'b1,
    module_reset_n: 1'b0,
    lock:           1'b0,
    warm_status:    1'b0
  };

endpackage

// ---- core/prs_sync.sv ----
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ps
module prs_sync
  import prs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= PRS_SYNC_RST;
      sync_reg <= PRS_SYNC_RST;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// ---- core/prs_sequencer.sv ----
// Processor reset sequencer: cold, hardware warm and watchdog resets.
// Assumes board reset pins are asynchronous; watchdog_expire is on clk.
`timescale 1ns/1ps

// Functional notes
// RULE1 - Three modes: cold, hardware warm, soft
// RULE2 - Cold reset resets everything including PLL
// RULE3 - Board holds both resets low 2000 ns
// RULE4 - Board releases power-on reset first
// RULE5 - System reset released 10 ns later; the board model releases it 3 cycles (12 ns) later
// RULE6 - Lock asserted after cold reset release
// RULE7 - Warm reset only after completed cold reset
// RULE8 - System reset alone: warm, PLL untouched
// RULE9 - Board holds system reset 500 ns
// RULE10 - Lock asserted after warm reset completes
// RULE11 - Watchdog soft reset acts like warm
// RULE12 - Status bit 4 set only by soft
// RULE13 - Synchronise inputs; no lock during reset
module prs_sequencer
  import prs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic power_on_reset_in_n,
  input  wire logic system_reset_in_n,
  input  wire logic watchdog_expire,
  output logic      pll_reset_out,
  output logic      module_reset_out_n,
  output logic      lock_out,
  output logic      warm_reset_status,
  output logic      cold_done_out,
  output logic [1:0] reset_mode_out
);

  localparam logic [PRS_CNT_W-1:0] COLD_LOAD = PRS_CNT_W'(PRS_COLD_SETTLE_CYC - 1);
  localparam logic [PRS_CNT_W-1:0] WARM_LOAD = PRS_CNT_W'(PRS_WARM_SETTLE_CYC - 1);
  localparam logic [PRS_CNT_W-1:0] SOFT_LOAD = PRS_CNT_W'(PRS_SOFT_HOLD_CYC - 1);

  logic [1:0] pins_sync;
  logic       por_n_s;
  logic       sys_n_s;
  prs_regs_t  r_reg;
  prs_regs_t  r_next;

  // Pins come straight from the board; never read raw
  prs_sync u_sync
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({power_on_reset_in_n, system_reset_in_n}),
    .sync_out (pins_sync)
  ); // RULE13

  assign por_n_s = pins_sync[1];
  assign sys_n_s = pins_sync[0];

  always_comb
  begin
    r_next = r_reg;
    case (r_reg.state)
      PRS_S_COLD:
      begin
        // Both pins must be high; release order is the board's job
        r_next.pll_reset      = 1'b1; // RULE2
        r_next.module_reset_n = 1'b0; // RULE2
        r_next.lock           = 1'b0; // RULE13
        r_next.warm_status    = 1'b0; // RULE12
        r_next.cold_done      = 1'b0;
        r_next.mode           = PRS_M_COLD; // RULE1
        if (por_n_s && sys_n_s)
        begin
          r_next.state     = PRS_S_SETTLE;
          r_next.cnt       = COLD_LOAD;
          r_next.pll_reset = 1'b0; // RULE6
        end
      end
      PRS_S_SETTLE:
      begin
        if (!sys_n_s)
        begin
          // Re-entering hold restarts the settle count from full
          r_next.state          = r_reg.cold_done ? PRS_S_WARM_HOLD : PRS_S_COLD; // RULE7
          r_next.module_reset_n = 1'b0;
          r_next.lock           = 1'b0;
        end
        else if (r_reg.cnt == '0)
        begin
          r_next.state          = PRS_S_RUN;
          r_next.module_reset_n = 1'b1;
          r_next.lock           = 1'b1; // RULE6 RULE10
          r_next.cold_done      = 1'b1;
        end
        else
        begin
          r_next.cnt = r_reg.cnt - PRS_CNT_W'(1);
        end
      end
      PRS_S_RUN:
      begin
        if (!sys_n_s)
        begin
          r_next.state          = PRS_S_WARM_HOLD; // RULE8
          r_next.module_reset_n = 1'b0;
          r_next.lock           = 1'b0; // RULE13
        end
        else if (watchdog_expire)
        begin
          r_next.state          = PRS_S_SOFT_HOLD; // RULE11
          r_next.cnt            = SOFT_LOAD;
          r_next.module_reset_n = 1'b0;
          r_next.lock           = 1'b0;
          r_next.warm_status    = 1'b1; // RULE12
          r_next.mode           = PRS_M_SOFT;
        end
      end
      PRS_S_WARM_HOLD:
      begin
        // PLL stays out of reset, so recovery is the short count
        r_next.warm_status = 1'b0; // RULE12
        r_next.mode        = PRS_M_WARM; // RULE8
        if (sys_n_s)
        begin
          r_next.state = PRS_S_SETTLE;
          r_next.cnt   = WARM_LOAD; // RULE10
        end
      end
      PRS_S_SOFT_HOLD:
      begin
        if (r_reg.cnt == '0)
        begin
          r_next.state = PRS_S_SETTLE;
          r_next.cnt   = WARM_LOAD; // RULE11
        end
        else
        begin
          r_next.cnt = r_reg.cnt - PRS_CNT_W'(1);
        end
      end
      default:
      begin
        r_next = PRS_REGS_RST;
      end
    endcase
    // Power-on reset overrides every mode
    if (!por_n_s)
    begin
      r_next       = PRS_REGS_RST; // RULE2
      r_next.state = PRS_S_COLD;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg <= PRS_REGS_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign pll_reset_out      = r_reg.pll_reset;
  assign module_reset_out_n = r_reg.module_reset_n;
  assign lock_out           = r_reg.lock;
  assign warm_reset_status  = r_reg.warm_status;
  assign cold_done_out      = r_reg.cold_done;
  assign reset_mode_out     = r_reg.mode;

  a_lock_in_reset: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    !r_reg.module_reset_n |-> !r_reg.lock)
    else $error("lock high while modules held in reset");

  a_cold_resets_pll: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    !por_n_s |=> r_reg.pll_reset && !r_reg.module_reset_n && !r_reg.cold_done)
    else $error("cold reset did not reset pll and modules");

  a_warm_keeps_pll: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    (r_reg.state == PRS_S_RUN && por_n_s && !sys_n_s) |=>
      !r_reg.pll_reset && !r_reg.module_reset_n && r_reg.state == PRS_S_WARM_HOLD)
    else $error("warm reset wrong scope");

  a_settle_gives_lock: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    (r_reg.state == PRS_S_SETTLE && r_reg.cnt == '0 && por_n_s && sys_n_s) |=>
      r_reg.lock && r_reg.cold_done)
    else $error("lock missing after release");

  a_cold_settle_len: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    (r_reg.state == PRS_S_COLD && por_n_s && sys_n_s) |=>
      r_reg.cnt == COLD_LOAD && !r_reg.pll_reset && !r_reg.lock)
    else $error("cold settle not loaded");

  a_warm_settle_len: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    (r_reg.state == PRS_S_WARM_HOLD && por_n_s && sys_n_s) |=>
      r_reg.state == PRS_S_SETTLE && r_reg.cnt == WARM_LOAD)
    else $error("warm settle not loaded");

  a_warm_needs_cold: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    r_reg.state == PRS_S_WARM_HOLD |-> r_reg.cold_done)
    else $error("warm hold without finished cold reset");

  a_soft_sets_status: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (r_reg.state == PRS_S_RUN && por_n_s && sys_n_s && watchdog_expire) |=>
      r_reg.warm_status && !r_reg.module_reset_n && !r_reg.pll_reset ##1
      (r_reg.state == PRS_S_SOFT_HOLD && r_reg.cnt == SOFT_LOAD - PRS_CNT_W'(1)))
    else $error("watchdog reset wrong");

  a_status_cleared: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    (r_reg.state == PRS_S_WARM_HOLD || !por_n_s) |=> !r_reg.warm_status)
    else $error("status bit not cleared by hardware reset");

  a_hold_keeps_pll: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (r_reg.state == PRS_S_SOFT_HOLD || r_reg.state == PRS_S_WARM_HOLD) |-> !r_reg.pll_reset)
    else $error("pll reset during warm or soft hold");

  a_lock_drops_sys: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    (r_reg.lock && !sys_n_s) |=> !r_reg.lock)
    else $error("lock kept while system reset asserted");

  a_soft_mode_kept: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    r_reg.state == PRS_S_SOFT_HOLD |-> r_reg.mode == PRS_M_SOFT)
    else $error("soft hold without soft mode");

  a_warm_mode_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    (r_reg.state == PRS_S_WARM_HOLD && por_n_s) |=> r_reg.mode == PRS_M_WARM)
    else $error("warm hold without warm mode");

  a_soft_hold_end: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (r_reg.state == PRS_S_SOFT_HOLD && r_reg.cnt == '0 && por_n_s) |=>
      r_reg.state == PRS_S_SETTLE && r_reg.cnt == WARM_LOAD && r_reg.warm_status)
    else $error("soft hold did not end in warm settle");

endmodule

// ---- sim/prs_board_model.sv ----
// Board supervisor model driving the reset pin pair.
// Assumes pull-ups on both pins; the bench calls its tasks.
`timescale 1ns/1ps
module prs_board_model
(
  input  wire logic clk,
  output logic      por_n,
  output logic      sys_n
);
  initial
  begin
    por_n = 1'b0;
    sys_n = 1'b0;
  end

  // Power-up sequence: both low, then staggered release
  task automatic cold_seq();
    @(posedge clk) #1;
    por_n = 1'b0;
    sys_n = 1'b0;
    repeat (500) @(posedge clk);
    #1 por_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 sys_n = 1'b1;
  endtask

  // System reset alone; power-on stays released
  task automatic sys_pulse(input int cyc);
    @(posedge clk) #1 sys_n = 1'b0;
    repeat (cyc) @(posedge clk);
    #1 sys_n = 1'b1;
  endtask
endmodule

// ---- sim/prs_sequencer_tb_top.sv ----
// Self-checking bench for the reset sequencer.
// Assumes the board model drives the pins; watchdog pulses come from here.
`timescale 1ns/1ps
module prs_sequencer_tb_top;
  import prs_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       wd;
  logic       por_n;
  logic       sys_n;
  logic       pll;
  logic       mrst_n;
  logic       lock;
  logic       status;
  logic       cdone;
  logic [1:0] mode;
  int         errors;
  int         n_tests;
  int         exp_mode;
  int         exp_status;

  prs_board_model i_brd (.clk(clk), .por_n(por_n), .sys_n(sys_n));

  prs_sequencer i_dut
  (
    .clk                 (clk),
    .rst_n               (rst_n),
    .power_on_reset_in_n (por_n),
    .system_reset_in_n   (sys_n),
    .watchdog_expire     (wd),
    .pll_reset_out       (pll),
    .module_reset_out_n  (mrst_n),
    .lock_out            (lock),
    .warm_reset_status   (status),
    .cold_done_out       (cdone),
    .reset_mode_out      (mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait, so a lock that never comes still ends the run
  task automatic wait_lock(input int exp_edges);
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 2000)
    begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 2000)
    begin
      errors++;
      final_report();
    end
    chk(16'(n), 16'(exp_edges));
    chk(16'({mrst_n, pll, cdone, status, mode}), 16'({3'h5, exp_status[0], exp_mode[1:0]}));
  endtask

  task automatic cold_check();
    // Two sync edges keep the PLL in reset, the third releases it
    repeat (2) @(posedge clk);
    #1 chk(16'(pll), 16'h0001);
    @(posedge clk) #1 chk(16'(pll), 16'h0000);
    exp_mode = 0;
    exp_status = 0;
    wait_lock(int'(PRS_COLD_SETTLE_CYC));
  endtask

  initial
  begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    wd = 1'b0;
    exp_mode = 0;
    exp_status = 0;
    void'($urandom(60331));
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    i_brd.cold_seq();
    cold_check();
    // System reset during settle only restarts the cold sequence
    repeat ($urandom_range(100, 5)) @(posedge clk);
    i_brd.cold_seq();
    repeat ($urandom_range(100, 20)) @(posedge clk);
    i_brd.sys_pulse($urandom_range(30, 10));
    chk(16'({pll, cdone, lock}), 16'h0004);
    cold_check();
    for (int i = 0; i < 8; i++)
    begin
      repeat ($urandom_range(40, 1)) @(posedge clk);
      #1;
      if ($urandom_range(1, 0) == 1)
      begin
        // Watchdog inside the warm hold must be ignored
        fork
          i_brd.sys_pulse(125);
          begin
            repeat (60) @(posedge clk);
            #1 wd = 1'b1;
            @(posedge clk) #1 wd = 1'b0;
          end
        join
        exp_mode = 1;
        exp_status = 0;
        chk(16'({lock, mrst_n, pll, status, mode}), 16'h0001);
        // Release passes two sync edges and one state edge before settle
        wait_lock(int'(PRS_WARM_SETTLE_CYC) + 3);
      end
      else
      begin
        wd = 1'b1;
        @(posedge clk) #1 wd = 1'b0;
        exp_mode = 2;
        exp_status = 1;
        chk(16'({lock, mrst_n, pll, status, mode}), 16'h0006);
        wait_lock(int'(PRS_SOFT_HOLD_CYC + PRS_WARM_SETTLE_CYC));
      end
    end
    // Reset in mid-run returns every output to its idle value
    rst_n = 1'b0;
    #1 chk(16'({pll, mrst_n, lock, status, cdone, mode}), 16'h0040);
    @(posedge clk) #1 rst_n = 1'b1;
    cold_check();
    final_report();
  end
endmodule
